// ---- design/srt_sdram_refresh_timer.sv ----
// Functional notes
// - clock select picks one of seven dividers; 010=/8
// - counter idle until a clock is selected
// - refresh enable is refresh control bit 7
// - 8-bit counter increments on each selected tick
// - match sets flag and clears counter to zero
// - match starts refresh only when enable set
// - interval compared against counter on every count
// - mode-set enable turns sdram byte writes into mode set
// - mode-set enable sits at sdram control bit 15
// - two-bit precharge field, 00 means one cycle
`timescale 1ns/10ps
module srt_sdram_refresh_timer (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic [srt_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [srt_pkg::DATA_W-1:0] regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [srt_pkg::DATA_W-1:0] regRdata,
  input  wire logic                      memWr,
  input  wire logic [srt_pkg::ADDR_W-1:0] memAddr,
  input  wire logic                      memByte,
  output logic                           memWrPass,
  output logic                           sdramCsN,
  output logic                           sdramRasN,
  output logic                           sdramCasN,
  output logic                           sdramWeN,
  output logic [srt_pkg::SDRAM_ADDR_W-1:0] sdramAddr,
  output logic                           irq
);

  localparam int IW = srt_pkg::IRQ_W;
  localparam int AW = srt_pkg::SDRAM_ADDR_W;

  // control registers
  logic [2:0]          clkSel_ff;
  logic [2:0]          nxt_clkSel;
  logic                refreshEn_ff;
  logic                nxt_refreshEn;
  logic                matchFlag_ff;
  logic                nxt_matchFlag;
  logic [7:0]          refreshCnt_ff;
  logic [7:0]          nxt_refreshCnt;
  logic [7:0]          refreshIntv_ff;
  logic [7:0]          nxt_refreshIntv;
  logic                modeSetEn_ff;
  logic                nxt_modeSetEn;
  logic [1:0]          precharge_ff;
  logic [1:0]          nxt_precharge;

  // request state
  logic                refreshPend_ff;
  logic                nxt_refreshPend;
  logic                modePend_ff;
  logic                nxt_modePend;
  logic [AW-1:0]       modeVal_ff;
  logic [AW-1:0]       nxt_modeVal;
  logic                memWrPass_ff;
  logic                nxt_memWrPass;

  // interrupt state
  logic [IW-1:0]       irqStatus_ff;
  logic [IW-1:0]       nxt_irqStatus;
  logic [IW-1:0]       irqEnable_ff;
  logic [IW-1:0]       nxt_irqEnable;
  logic                irq_ff;
  logic                nxt_irq;

  // read port
  logic [srt_pkg::DATA_W-1:0] rdata_ff;
  logic [srt_pkg::DATA_W-1:0] nxt_rdata;

  // internal
  logic                tick;
  logic                counting;
  logic                matchEv;
  logic                startRefresh;
  logic                startMode;
  logic                seqBusy;
  logic                doneRefresh;
  logic                doneMode;
  logic [3:0]          sdramCmd;
  logic [AW-1:0]       seqAddr;
  logic [IW-1:0]       events;
  logic [IW-1:0]       clearMask;

  function automatic logic hit(input logic [srt_pkg::ADDR_W-1:0] a,
                               input logic [srt_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  srt_prescaler u_prescaler (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clkSel   (clkSel_ff),
    .tick     (tick)
  );

  srt_sdram_cmd u_cmd (
    .core_clk        (core_clk),
    .nrst            (nrst),
    .startRefresh    (startRefresh),
    .startMode       (startMode),
    .modeValue       (modeVal_ff),
    .prechargeCycles (precharge_ff),
    .busy            (seqBusy),
    .doneRefresh     (doneRefresh),
    .doneMode        (doneMode),
    .sdramCmd        (sdramCmd),
    .sdramAddr       (seqAddr)
  );

  // counter, compare and flag
  always_comb begin
    counting        = tick && (clkSel_ff != 3'h0);
    matchEv         = counting && (refreshCnt_ff == refreshIntv_ff);
    nxt_clkSel      = clkSel_ff;
    nxt_refreshEn   = refreshEn_ff;
    nxt_matchFlag   = matchFlag_ff;
    nxt_refreshCnt  = refreshCnt_ff;
    nxt_refreshIntv = refreshIntv_ff;
    nxt_modeSetEn   = modeSetEn_ff;
    nxt_precharge   = precharge_ff;
    if (counting) begin
      if (matchEv) begin
        nxt_refreshCnt = 8'h00;
      end else begin
        nxt_refreshCnt = 8'(refreshCnt_ff + 8'h01);
      end
    end
    if (regWr && hit(regAddr, srt_pkg::OFF_REFRESH_CTRL)) begin
      nxt_clkSel    = regWdata[srt_pkg::CLK_SEL_LSB +: srt_pkg::CLK_SEL_W];
      nxt_refreshEn = regWdata[srt_pkg::REFRESH_EN_BIT];
      // flag clears by writing zero; writing one leaves it alone
      if (!regWdata[srt_pkg::MATCH_FLAG_BIT]) begin
        nxt_matchFlag = 1'b0;
      end
    end
    // software load wins over the running count
    if (regWr && hit(regAddr, srt_pkg::OFF_REFRESH_CNT)) begin
      nxt_refreshCnt = regWdata[7:0];
    end
    if (regWr && hit(regAddr, srt_pkg::OFF_REFRESH_INTV)) begin
      nxt_refreshIntv = regWdata[7:0];
    end
    if (regWr && hit(regAddr, srt_pkg::OFF_SDRAM_CTRL)) begin
      nxt_modeSetEn = regWdata[srt_pkg::MODE_SET_EN_BIT];
    end
    if (regWr && hit(regAddr, srt_pkg::OFF_ACCESS_CTRL)) begin
      nxt_precharge = regWdata[srt_pkg::PRECHARGE_LSB +: srt_pkg::PRECHARGE_W];
    end
    // a match in the clearing cycle is kept
    if (matchEv) begin
      nxt_matchFlag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clkSel_ff      <= srt_pkg::CLK_SEL_RST;
      refreshEn_ff   <= 1'b0;
      matchFlag_ff   <= 1'b0;
      refreshCnt_ff  <= srt_pkg::CNT_RST;
      refreshIntv_ff <= srt_pkg::INTV_RST;
      modeSetEn_ff   <= 1'b0;
      precharge_ff   <= srt_pkg::PRECHARGE_RST;
    end else begin
      clkSel_ff      <= nxt_clkSel;
      refreshEn_ff   <= nxt_refreshEn;
      matchFlag_ff   <= nxt_matchFlag;
      refreshCnt_ff  <= nxt_refreshCnt;
      refreshIntv_ff <= nxt_refreshIntv;
      modeSetEn_ff   <= nxt_modeSetEn;
      precharge_ff   <= nxt_precharge;
    end
  end

  // refresh and mode-set requests toward the command sequencer
  always_comb begin
    startRefresh    = refreshPend_ff && !seqBusy;
    startMode       = modePend_ff && !seqBusy && !refreshPend_ff;
    nxt_refreshPend = refreshPend_ff;
    nxt_modePend    = modePend_ff;
    nxt_modeVal     = modeVal_ff;
    nxt_memWrPass   = 1'b0;
    if (startRefresh) begin
      nxt_refreshPend = 1'b0;
    end
    if (startMode) begin
      nxt_modePend = 1'b0;
    end
    // enable sampled in the match cycle itself
    if (matchEv && refreshEn_ff) begin
      nxt_refreshPend = 1'b1;
    end
    if (memWr) begin
      if (!modeSetEn_ff) begin
        nxt_memWrPass = 1'b1;
      end else if (memByte) begin
        // a second byte write before the first is issued replaces it
        nxt_modePend = 1'b1;
        nxt_modeVal  = memAddr[srt_pkg::MODE_ADDR_LSB +: AW];
      end
      // wider writes while mode set is enabled are dropped
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      refreshPend_ff <= 1'b0;
      modePend_ff    <= 1'b0;
      modeVal_ff     <= '0;
      memWrPass_ff   <= 1'b0;
    end else begin
      refreshPend_ff <= nxt_refreshPend;
      modePend_ff    <= nxt_modePend;
      modeVal_ff     <= nxt_modeVal;
      memWrPass_ff   <= nxt_memWrPass;
    end
  end

  // interrupt status, enable and output
  always_comb begin
    events                          = '0;
    events[srt_pkg::EV_MATCH]       = matchEv;
    events[srt_pkg::EV_REFRESH]     = doneRefresh;
    events[srt_pkg::EV_MODE]        = doneMode;
    // overrun: a match while the previous refresh is still waiting
    events[srt_pkg::EV_OVERRUN]     = matchEv && refreshEn_ff && refreshPend_ff
                                      && !startRefresh;
    clearMask = '0;
    if (regWr && hit(regAddr, srt_pkg::OFF_IRQ_CLEAR)) begin
      clearMask = regWdata[IW-1:0];
    end
    nxt_irqEnable = irqEnable_ff;
    if (regWr && hit(regAddr, srt_pkg::OFF_IRQ_ENABLE)) begin
      nxt_irqEnable = regWdata[IW-1:0];
    end
    nxt_irqStatus = (irqStatus_ff & ~clearMask) | events;
    nxt_irq       = |(nxt_irqStatus & nxt_irqEnable);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus_ff <= '0;
      irqEnable_ff <= '0;
      irq_ff       <= 1'b0;
    end else begin
      irqStatus_ff <= nxt_irqStatus;
      irqEnable_ff <= nxt_irqEnable;
      irq_ff       <= nxt_irq;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = '0;
    if (regRd) begin
      case (regAddr)
        srt_pkg::OFF_REFRESH_CTRL: begin
          nxt_rdata[srt_pkg::CLK_SEL_LSB +: srt_pkg::CLK_SEL_W] = clkSel_ff;
          nxt_rdata[srt_pkg::REFRESH_EN_BIT]                   = refreshEn_ff;
          nxt_rdata[srt_pkg::MATCH_FLAG_BIT]                   = matchFlag_ff;
        end
        srt_pkg::OFF_REFRESH_CNT:  nxt_rdata[7:0] = refreshCnt_ff;
        srt_pkg::OFF_REFRESH_INTV: nxt_rdata[7:0] = refreshIntv_ff;
        srt_pkg::OFF_SDRAM_CTRL:   nxt_rdata[srt_pkg::MODE_SET_EN_BIT] = modeSetEn_ff;
        srt_pkg::OFF_ACCESS_CTRL: begin
          nxt_rdata[srt_pkg::PRECHARGE_LSB +: srt_pkg::PRECHARGE_W] = precharge_ff;
        end
        srt_pkg::OFF_IRQ_STATUS:   nxt_rdata[IW-1:0] = irqStatus_ff;
        srt_pkg::OFF_IRQ_ENABLE:   nxt_rdata[IW-1:0] = irqEnable_ff;
        default:                   nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign regRdata  = rdata_ff;
  assign memWrPass = memWrPass_ff;
  assign irq       = irq_ff;
  assign sdramCsN  = sdramCmd[3];
  assign sdramRasN = sdramCmd[2];
  assign sdramCasN = sdramCmd[1];
  assign sdramWeN  = sdramCmd[0];
  assign sdramAddr = seqAddr;

endmodule // srt_sdram_refresh_timer

// ---- design/srt_pkg.sv ----
package srt_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // register byte addresses
  localparam logic [23:0] OFF_ACCESS_CTRL  = 24'hfffda2;
  localparam logic [23:0] OFF_SDRAM_CTRL   = 24'hfffda4;
  localparam logic [23:0] OFF_REFRESH_CTRL = 24'hfffda6;
  localparam logic [23:0] OFF_REFRESH_CNT  = 24'hfffda8;
  localparam logic [23:0] OFF_REFRESH_INTV = 24'hfffda9;
  localparam logic [23:0] OFF_IRQ_STATUS   = 24'hfffdb0;
  localparam logic [23:0] OFF_IRQ_CLEAR    = 24'hfffdb2;
  localparam logic [23:0] OFF_IRQ_ENABLE   = 24'hfffdb4;

  // field positions
  localparam int CLK_SEL_LSB     = 8;
  localparam int CLK_SEL_W       = 3;
  localparam int REFRESH_EN_BIT  = 7;
  localparam int MATCH_FLAG_BIT  = 6;
  localparam int MODE_SET_EN_BIT = 15;
  localparam int PRECHARGE_LSB   = 12;
  localparam int PRECHARGE_W     = 2;

  // reset values
  localparam logic [2:0] CLK_SEL_RST   = 3'h0;
  localparam logic [7:0] CNT_RST       = 8'h00;
  localparam logic [7:0] INTV_RST      = 8'hff;
  localparam logic [1:0] PRECHARGE_RST = 2'h0;

  // interrupt events
  localparam int IRQ_W       = 4;
  localparam int EV_MATCH    = 0;
  localparam int EV_REFRESH  = 1;
  localparam int EV_MODE     = 2;
  localparam int EV_OVERRUN  = 3;

  // sdram side
  localparam int SDRAM_ADDR_W      = 12;
  localparam int MODE_ADDR_LSB     = 1;
  localparam int PRECHARGE_ALL_BIT = 10;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP       = 4'h7;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_MODE_SET  = 4'h0;

  // prescaler
  localparam int DIV_W = 12;

  typedef enum logic [0:0] {ST_IDLE, ST_PRECHARGE_WAIT} srt_seq_state_e;

endpackage

// ---- design/srt_prescaler.sv ----
`timescale 1ns/10ps
module srt_prescaler (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] clkSel,
  output logic            tick
);

  localparam int DIV_W = srt_pkg::DIV_W;

  logic [srt_pkg::DIV_W-1:0] divCnt_ff;
  logic [srt_pkg::DIV_W-1:0] nxt_divCnt;
  logic                      tick_ff;
  logic                      nxt_tick;
  logic [srt_pkg::DIV_W-1:0] mask;

  // low bits all ones once per divided period
  function automatic logic [srt_pkg::DIV_W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h1:    div_mask = 12'h001;
      3'h2:    div_mask = 12'h007;
      3'h3:    div_mask = 12'h01f;
      3'h4:    div_mask = 12'h07f;
      3'h5:    div_mask = 12'h1ff;
      3'h6:    div_mask = 12'h7ff;
      3'h7:    div_mask = 12'hfff;
      default: div_mask = 12'h000;
    endcase
  endfunction

  always_comb begin
    mask       = div_mask(clkSel);
    nxt_divCnt = DIV_W'(divCnt_ff + 12'h001);
    nxt_tick   = (clkSel != 3'h0) && ((divCnt_ff & mask) == mask);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_ff <= 12'h000;
      tick_ff   <= 1'b0;
    end else begin
      divCnt_ff <= nxt_divCnt;
      tick_ff   <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule // srt_prescaler

// ---- design/srt_sdram_cmd.sv ----
`timescale 1ns/10ps
module srt_sdram_cmd (
  input  wire logic                            core_clk,
  input  wire logic                            nrst,
  input  wire logic                            startRefresh,
  input  wire logic                            startMode,
  input  wire logic [srt_pkg::SDRAM_ADDR_W-1:0] modeValue,
  input  wire logic [1:0]                      prechargeCycles,
  output logic                                 busy,
  output logic                                 doneRefresh,
  output logic                                 doneMode,
  output logic [3:0]                           sdramCmd,
  output logic [srt_pkg::SDRAM_ADDR_W-1:0]      sdramAddr
);

  srt_pkg::srt_seq_state_e                state_ff, nxt_state;
  logic                                   isRefresh_ff, nxt_isRefresh;
  logic [1:0]                             wait_ff, nxt_wait;
  logic [3:0]                             cmd_ff, nxt_cmd;
  logic [srt_pkg::SDRAM_ADDR_W-1:0]        addr_ff, nxt_addr;
  logic [srt_pkg::SDRAM_ADDR_W-1:0]        modeHold_ff, nxt_modeHold;
  logic                                   doneRef_ff, nxt_doneRef;
  logic                                   doneMode_ff, nxt_doneMode;

  always_comb begin
    nxt_state     = state_ff;
    nxt_isRefresh = isRefresh_ff;
    nxt_wait      = wait_ff;
    nxt_cmd       = srt_pkg::CMD_NOP;
    nxt_addr      = '0;
    nxt_modeHold  = modeHold_ff;
    nxt_doneRef   = 1'b0;
    nxt_doneMode  = 1'b0;
    case (state_ff)
      srt_pkg::ST_IDLE: begin
        if (startRefresh || startMode) begin
          // refresh wins a tie so a waiting mode set never goes ahead of it; one already in progress still delays it
          nxt_isRefresh = startRefresh;
          nxt_modeHold  = modeValue;
          nxt_cmd       = srt_pkg::CMD_PRECHARGE;
          nxt_addr[srt_pkg::PRECHARGE_ALL_BIT] = 1'b1;
          nxt_wait      = prechargeCycles;
          nxt_state     = srt_pkg::ST_PRECHARGE_WAIT;
        end
      end
      srt_pkg::ST_PRECHARGE_WAIT: begin
        if (wait_ff == 2'h0) begin
          nxt_state = srt_pkg::ST_IDLE;
          if (isRefresh_ff) begin
            nxt_cmd     = srt_pkg::CMD_REFRESH;
            nxt_doneRef = 1'b1;
          end else begin
            nxt_cmd      = srt_pkg::CMD_MODE_SET;
            nxt_addr     = modeHold_ff;
            nxt_doneMode = 1'b1;
          end
        end else begin
          nxt_wait = 2'(wait_ff - 2'h1);
        end
      end
      default: nxt_state = srt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff     <= srt_pkg::ST_IDLE;
      isRefresh_ff <= 1'b0;
      wait_ff      <= 2'h0;
      cmd_ff       <= srt_pkg::CMD_NOP;
      addr_ff      <= '0;
      modeHold_ff  <= '0;
      doneRef_ff   <= 1'b0;
      doneMode_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      isRefresh_ff <= nxt_isRefresh;
      wait_ff      <= nxt_wait;
      cmd_ff       <= nxt_cmd;
      addr_ff      <= nxt_addr;
      modeHold_ff  <= nxt_modeHold;
      doneRef_ff   <= nxt_doneRef;
      doneMode_ff  <= nxt_doneMode;
    end
  end

  assign busy        = (state_ff != srt_pkg::ST_IDLE);
  assign doneRefresh = doneRef_ff;
  assign doneMode    = doneMode_ff;
  assign sdramCmd    = cmd_ff;
  assign sdramAddr   = addr_ff;

endmodule // srt_sdram_cmd

// ---- dv/srt_sdram_model.sv ----
`timescale 1ns/10ps
module srt_sdram_model (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        csN,
  input wire logic        rasN,
  input wire logic        casN,
  input wire logic        weN,
  input wire logic [11:0] addr
);
  // the device only listens; it keeps stamps so the bench can judge spacing
  int          cyc;
  int          preCyc;
  int          lastRefCyc;
  int          refreshCount;
  int          modeCount;
  int          lastGap;
  int          refPeriod;
  logic [11:0] lastMode;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyc          <= 0;
      preCyc       <= 0;
      lastRefCyc   <= 0;
      refreshCount <= 0;
      modeCount    <= 0;
      lastGap      <= 0;
      refPeriod    <= 0;
      lastMode     <= 12'h000;
    end else begin
      cyc <= cyc + 1;
      case ({csN, rasN, casN, weN})
        srt_pkg::CMD_PRECHARGE: preCyc <= cyc;
        srt_pkg::CMD_REFRESH: begin
          refreshCount <= refreshCount + 1;
          lastGap      <= cyc - preCyc;
          refPeriod    <= cyc - lastRefCyc;
          lastRefCyc   <= cyc;
        end
        srt_pkg::CMD_MODE_SET: begin
          modeCount <= modeCount + 1;
          lastGap   <= cyc - preCyc;
          lastMode  <= addr;
        end
        default: ;
      endcase
    end
  end
endmodule // srt_sdram_model

// ---- dv/srt_sdram_refresh_timer_checker.sv ----
`timescale 1ns/10ps
module srt_sdram_refresh_timer_checker (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [23:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic        memWr,
  input wire logic [23:0] memAddr,
  input wire logic        memByte,
  input wire logic        memWrPass,
  input wire logic        sdramCsN,
  input wire logic        sdramRasN,
  input wire logic        sdramCasN,
  input wire logic        sdramWeN,
  input wire logic [11:0] sdramAddr,
  input wire logic        irq
);
  logic [3:0]  cmd;
  logic        modeEn_ff;
  logic        refEn_ff;
  logic [4:0]  offCnt_ff;
  logic [11:0] modeVal_ff;
  logic        nxt_modeEn;
  logic        nxt_refEn;
  logic [4:0]  nxt_offCnt;
  logic [11:0] nxt_modeVal;

  assign cmd = {sdramCsN, sdramRasN, sdramCasN, sdramWeN};

  // shadows of software state, rebuilt from bus traffic only
  always_comb begin
    nxt_modeEn  = modeEn_ff;
    nxt_refEn   = refEn_ff;
    nxt_modeVal = modeVal_ff;
    nxt_offCnt  = refEn_ff ? 5'h00 : ((offCnt_ff == 5'h1f) ? offCnt_ff : offCnt_ff + 5'h01);
    if (regWr && regAddr == srt_pkg::OFF_SDRAM_CTRL) nxt_modeEn = regWdata[15];
    if (regWr && regAddr == srt_pkg::OFF_REFRESH_CTRL) nxt_refEn = regWdata[7];
    if (memWr && modeEn_ff && memByte) nxt_modeVal = memAddr[12:1];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      modeEn_ff  <= 1'b0;
      refEn_ff   <= 1'b0;
      offCnt_ff  <= 5'h1f;
      modeVal_ff <= 12'h000;
    end else begin
      modeEn_ff  <= nxt_modeEn;
      refEn_ff   <= nxt_refEn;
      offCnt_ff  <= nxt_offCnt;
      modeVal_ff <= nxt_modeVal;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_pre;
    cmd == srt_pkg::CMD_PRECHARGE && sdramAddr[10];
  endsequence
  sequence s_nop;
    cmd == srt_pkg::CMD_NOP;
  endsequence

  chk_rdata_idle_zero: assert property (
    !$past(regRd) |-> regRdata == 16'h0000) else $error("read data outside read slot");
  chk_unmapped_rd_zero: assert property (
    regRd && regAddr == 24'hfffd00 |=> regRdata == 16'h0000) else $error("unmapped read");
  chk_pre_then_nop: assert property (
    cmd == srt_pkg::CMD_PRECHARGE |-> s_pre ##1 (cmd == srt_pkg::CMD_NOP
      || cmd == srt_pkg::CMD_REFRESH || cmd == srt_pkg::CMD_MODE_SET))
    else $error("precharge not followed");
  chk_ref_after_pre: assert property (
    cmd == srt_pkg::CMD_REFRESH |-> $past(cmd, 1) == srt_pkg::CMD_PRECHARGE
      || $past(cmd, 2) == srt_pkg::CMD_PRECHARGE || $past(cmd, 3) == srt_pkg::CMD_PRECHARGE
      || $past(cmd, 4) == srt_pkg::CMD_PRECHARGE) else $error("refresh without precharge");
  chk_cmd_one_cycle: assert property (
    cmd == srt_pkg::CMD_REFRESH || cmd == srt_pkg::CMD_MODE_SET |=>
      cmd == srt_pkg::CMD_NOP || cmd == srt_pkg::CMD_PRECHARGE)
    else $error("command held too long");
  chk_ref_needs_en: assert property (
    cmd == srt_pkg::CMD_REFRESH |-> offCnt_ff < 5'd20) else $error("refresh while disabled");
  chk_pass_when_off: assert property (
    memWr && !modeEn_ff |=> memWrPass) else $error("data write not passed");
  chk_block_when_on: assert property (
    memWr && modeEn_ff |=> !memWrPass) else $error("mode write passed as data");
  chk_mode_follows: assert property (
    memWr && modeEn_ff && memByte |-> ##[3:20] cmd == srt_pkg::CMD_MODE_SET)
    else $error("mode set missing");
  chk_mode_addr_val: assert property (
    cmd == srt_pkg::CMD_MODE_SET |-> sdramAddr == modeVal_ff) else $error("mode value wrong");
endmodule // srt_sdram_refresh_timer_checker

bind srt_sdram_refresh_timer srt_sdram_refresh_timer_checker u_srt_sdram_refresh_timer_checker (
  .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .memWr(memWr), .memAddr(memAddr), .memByte(memByte),
  .memWrPass(memWrPass), .sdramCsN(sdramCsN), .sdramRasN(sdramRasN), .sdramCasN(sdramCasN),
  .sdramWeN(sdramWeN), .sdramAddr(sdramAddr), .irq(irq));

// ---- dv/srt_sdram_refresh_timer_bench.sv ----
`timescale 1ns/10ps
module srt_sdram_refresh_timer_bench;
  logic        core_clk  = 1'b0;
  logic        nrst      = 1'b0;
  logic [23:0] regAddr   = 24'h000000;
  logic [15:0] regWdata  = 16'h0000;
  logic        regWr     = 1'b0;
  logic        regRd     = 1'b0;
  logic [15:0] regRdata;
  logic        memWr     = 1'b0;
  logic [23:0] memAddr   = 24'h000000;
  logic        memByte   = 1'b0;
  logic        memWrPass;
  logic        sdramCsN;
  logic        sdramRasN;
  logic        sdramCasN;
  logic        sdramWeN;
  logic [11:0] sdramAddr;
  logic        irq;
  logic        passv;
  int          errCount   = 0;
  int          nCompared  = 0;
  int          i;
  int          nRef;
  logic [23:0] rstAddr [9] = '{24'hfffda2, 24'hfffda4, 24'hfffda6, 24'hfffda8, 24'hfffda9,
                               24'hfffdb0, 24'hfffdb2, 24'hfffdb4, 24'hfffd00};
  logic [15:0] rstVal  [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00ff,
                               16'h0000, 16'h0000, 16'h0000, 16'h0000};

  always #5 core_clk = ~core_clk;

  srt_sdram_refresh_timer u_srt_sdram_refresh_timer (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .memWr(memWr), .memAddr(memAddr), .memByte(memByte),
    .memWrPass(memWrPass), .sdramCsN(sdramCsN), .sdramRasN(sdramRasN), .sdramCasN(sdramCasN),
    .sdramWeN(sdramWeN), .sdramAddr(sdramAddr), .irq(irq));

  srt_sdram_model u_srt_sdram_model (
    .core_clk(core_clk), .nrst(nrst), .csN(sdramCsN), .rasN(sdramRasN), .casN(sdramCasN),
    .weN(sdramWeN), .addr(sdramAddr));

  task automatic stop_test();
    if (errCount == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdc(input logic [23:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    check(regRdata, exp);
  endtask

  task automatic memw(input logic [23:0] a, input logic b, output logic p);
    @(posedge core_clk);
    memWr   <= 1'b1;
    memAddr <= a;
    memByte <= b;
    @(posedge core_clk);
    memWr <= 1'b0;
    #1;
    p = memWrPass;
  endtask

  task automatic waitEv(input bit isMode);
    int start;
    int k;
    start = isMode ? u_srt_sdram_model.modeCount : u_srt_sdram_model.refreshCount;
    for (k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      #1;
      if ((isMode ? u_srt_sdram_model.modeCount : u_srt_sdram_model.refreshCount) != start)
        return;
    end
    errCount++;
    stop_test();
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (i = 0; i < 9; i++) rdc(rstAddr[i], rstVal[i]);
    repeat (100) @(posedge core_clk);
    rdc(srt_pkg::OFF_REFRESH_CNT, 16'h0000);
    wr(srt_pkg::OFF_REFRESH_CNT, 16'h0005);
    rdc(srt_pkg::OFF_REFRESH_CNT, 16'h0005);
    // interval 3 at /8 gives a match every 32 core cycles
    wr(srt_pkg::OFF_REFRESH_INTV, 16'h0003);
    wr(srt_pkg::OFF_REFRESH_CNT, 16'h0000);
    wr(srt_pkg::OFF_REFRESH_CTRL, 16'h0280);
    waitEv(0);
    waitEv(0);
    check(u_srt_sdram_model.refPeriod, 32);
    check(u_srt_sdram_model.lastGap, 1);
    rdc(srt_pkg::OFF_REFRESH_CNT, 16'h0000);
    rdc(srt_pkg::OFF_REFRESH_CTRL, 16'h02c0);
    wr(srt_pkg::OFF_REFRESH_CTRL, 16'h0280);
    rdc(srt_pkg::OFF_REFRESH_CTRL, 16'h0280);
    wr(srt_pkg::OFF_REFRESH_INTV, 16'h0007);
    waitEv(0);
    waitEv(0);
    waitEv(0);
    check(u_srt_sdram_model.refPeriod, 64);
    wr(srt_pkg::OFF_ACCESS_CTRL, 16'h3000);
    waitEv(0);
    check(u_srt_sdram_model.lastGap, 4);
    rdc(srt_pkg::OFF_ACCESS_CTRL, 16'h3000);
    wr(srt_pkg::OFF_REFRESH_CTRL, 16'h0200);
    nRef = u_srt_sdram_model.refreshCount;
    repeat (200) @(posedge core_clk);
    check(u_srt_sdram_model.refreshCount, nRef);
    rdc(srt_pkg::OFF_REFRESH_CTRL, 16'h0240);
    wr(srt_pkg::OFF_REFRESH_CTRL, 16'h0000);
    wr(srt_pkg::OFF_ACCESS_CTRL, 16'h0000);
    repeat (20) @(posedge core_clk);
    rdc(srt_pkg::OFF_IRQ_STATUS, 16'h0003);
    wr(srt_pkg::OFF_IRQ_CLEAR, 16'h000f);
    rdc(srt_pkg::OFF_IRQ_STATUS, 16'h0000);
    wr(srt_pkg::OFF_IRQ_ENABLE, 16'h0004);
    wr(srt_pkg::OFF_SDRAM_CTRL, 16'h8000);
    rdc(srt_pkg::OFF_SDRAM_CTRL, 16'h8000);
    memw(24'h000246, 1'b1, passv);
    check(passv, 1'b0);
    waitEv(1);
    check(u_srt_sdram_model.lastMode, 12'h123);
    rdc(srt_pkg::OFF_IRQ_STATUS, 16'h0004);
    check(irq, 1'b1);
    // a word-size write while mode-set is on must be dropped
    memw(24'h000800, 1'b0, passv);
    check(passv, 1'b0);
    repeat (20) @(posedge core_clk);
    check(u_srt_sdram_model.modeCount, 1);
    wr(srt_pkg::OFF_IRQ_CLEAR, 16'h0004);
    rdc(srt_pkg::OFF_IRQ_STATUS, 16'h0000);
    check(irq, 1'b0);
    wr(srt_pkg::OFF_IRQ_ENABLE, 16'h0000);
    memw(24'h000464, 1'b1, passv);
    waitEv(1);
    check(u_srt_sdram_model.lastMode, 12'h232);
    rdc(srt_pkg::OFF_IRQ_STATUS, 16'h0004);
    check(irq, 1'b0);
    wr(srt_pkg::OFF_SDRAM_CTRL, 16'h0000);
    memw(24'h000100, 1'b1, passv);
    check(passv, 1'b1);
    repeat (20) @(posedge core_clk);
    check(u_srt_sdram_model.modeCount, 2);
    stop_test();
  end
endmodule // srt_sdram_refresh_timer_bench
